// file: hdl/dao_output_stage.sv
// two-channel audio output stage: gating, inversion, amplitude, dither
// assumes an APB master on mclk and a sample_tick pulse per sample
//
// Behaviour
// (RULE1) drive only selected channels while output on
// (RULE2) inverted channel outputs negated samples
// (RULE3) equal inversion settings keep channels in phase
// (RULE4) each channel scaled by own amplitude
// (RULE5) tracking applies channel A amplitude to both
// (RULE6) each master control write toggles output state; the code toggles only on writes with pwdata[0] set
// (RULE7) code amplitude is the peak sample value
// (RULE8) dither added before quantization
// (RULE9) dither amplitude follows output resolution
// (RULE10) triangular dither peaks at one LSB
// (RULE11) rectangular dither peaks at half LSB
// (RULE12) shaped dither: differenced triangular, unity at Nyquist
// (RULE13) dither type none adds nothing
// (RULE14) relative level: decibels applied to reference
// (RULE15) analog units converted via volts per full scale
// (RULE16) per-channel random generators advance per sample

module dao_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  // depth must be a power of two: full is told by the wrap bit
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign level     = wr_ptr - rd_ptr;
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk)
  begin
    if (in_valid && in_ready)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      wr_ptr <= '0;
    else if (in_valid && in_ready)
      wr_ptr <= wr_ptr + 1'b1;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rd_ptr <= '0;
    else if (out_valid && out_ready)
      rd_ptr <= rd_ptr + 1'b1;
  end
endmodule : dao_fifo

module dao_output_stage #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               src_valid,
  output logic                    src_ready,
  input  wire dao_pkg::dao_pair_s src_data,
  input  wire logic               sample_tick,
  output logic                    out_valid,
  output dao_pkg::dao_pair_s      out_data,
  output logic [1:0]              out_active
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [dao_pkg::CTRL_W-1:0] ctrl;
  logic [dao_pkg::AMP_W-1:0]  amp_a;
  logic [dao_pkg::AMP_W-1:0]  amp_b;
  logic [dao_pkg::AMP_W-1:0]  rel_ref;
  logic [dao_pkg::AMP_W-1:0]  vpfs;
  logic [4:0]                 res;
  logic                       out_on;
  logic                       underrun;
  logic                       next_underrun;

  logic                       setup;
  logic                       wr_en;
  logic                       mapped;
  logic [31:0]                rd_mux;

  logic                       f_valid;
  logic                       pop;
  dao_pkg::dao_pair_s         f_data;
  logic [LW-1:0]              f_level;

  logic [4:0]                 res_eff;
  logic [4:0]                 shift;
  dao_pkg::dao_dither_e       dith_type;
  dao_pkg::dao_unit_e         unit;
  logic [dao_pkg::AMP_W-1:0]  ref_code;
  logic [dao_pkg::AMP_W-1:0]  amp_eff [2];
  logic [dao_pkg::AMP_W-1:0]  amp_sel [2];
  logic signed [dao_pkg::SAMPLE_W-1:0] in_s [2];
  logic signed [dao_pkg::SAMPLE_W-1:0] out_s [2];

  // ---------------- APB slave ----------------
  assign setup  = psel && !penable;
  assign pready = psel && penable;
  assign wr_en  = psel && penable && pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    case (paddr)
      dao_pkg::ADDR_CTRL:    rd_mux = 32'(ctrl);
      dao_pkg::ADDR_TOGGLE:  rd_mux = 32'(out_on);
      dao_pkg::ADDR_AMP_A:   rd_mux = 32'(amp_a);
      dao_pkg::ADDR_AMP_B:   rd_mux = 32'(amp_b);
      dao_pkg::ADDR_REL_REF: rd_mux = 32'(rel_ref);
      dao_pkg::ADDR_VPFS:    rd_mux = 32'(vpfs);
      dao_pkg::ADDR_RES:     rd_mux = 32'(res);
      dao_pkg::ADDR_STATUS:
      begin
        rd_mux[dao_pkg::STAT_ON]    = out_on;
        rd_mux[dao_pkg::STAT_UNDER] = underrun;
        rd_mux[dao_pkg::STAT_LVL +: LW] = f_level;
      end
      default:               mapped = 1'b0;
    endcase
  end

  // answer is captured in setup, shown during the access phase
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ctrl    <= dao_pkg::CTRL_RST;
      amp_a   <= dao_pkg::AMP_RST;
      amp_b   <= dao_pkg::AMP_RST;
      rel_ref <= dao_pkg::REF_RST;
      vpfs    <= dao_pkg::VPFS_RST;
      res     <= dao_pkg::RES_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        dao_pkg::ADDR_CTRL:    ctrl    <= pwdata[dao_pkg::CTRL_W-1:0];
        dao_pkg::ADDR_AMP_A:   amp_a   <= pwdata[dao_pkg::AMP_W-1:0];
        dao_pkg::ADDR_AMP_B:   amp_b   <= pwdata[dao_pkg::AMP_W-1:0];
        dao_pkg::ADDR_REL_REF: rel_ref <= pwdata[dao_pkg::AMP_W-1:0];
        dao_pkg::ADDR_VPFS:    vpfs    <= pwdata[dao_pkg::AMP_W-1:0];
        dao_pkg::ADDR_RES:     res     <= pwdata[4:0];
        default:               ;
      endcase
    end
  end

  // (RULE6) master toggle
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      out_on <= 1'b0;
    else if (wr_en && paddr == dao_pkg::ADDR_TOGGLE && pwdata[0])
      out_on <= !out_on;
  end

  // set wins over the write-one clear
  always_comb
  begin
    next_underrun = underrun;
    if (wr_en && paddr == dao_pkg::ADDR_STATUS &&
        pwdata[dao_pkg::STAT_UNDER])
      next_underrun = 1'b0;
    if (sample_tick && !f_valid)
      next_underrun = 1'b1;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      underrun <= 1'b0;
    else
      underrun <= next_underrun;
  end

  // ---------------- sample buffer ----------------
  assign pop = sample_tick && f_valid;

  dao_fifo #(
    .WIDTH ($bits(dao_pkg::dao_pair_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data),
    .level     (f_level)
  );

  // an empty buffer sends silence rather than a stale sample
  assign in_s[0] = f_valid ? f_data.ch_a : '0;
  assign in_s[1] = f_valid ? f_data.ch_b : '0;

  // ---------------- amplitude resolution ----------------
  assign dith_type = dao_pkg::dao_dither_e'(ctrl[dao_pkg::CTRL_DITH +: 2]);
  assign unit      = dao_pkg::dao_unit_e'(ctrl[dao_pkg::CTRL_UNIT +: 2]);
  // (RULE5) B follows A
  assign amp_sel[0] = amp_a;
  assign amp_sel[1] = ctrl[dao_pkg::CTRL_TRACK] ? amp_a : amp_b;

  function automatic logic [dao_pkg::AMP_W-1:0] to_code(
    input logic [dao_pkg::AMP_W-1:0] mv,
    input logic [dao_pkg::AMP_W-1:0] fs);
    logic [31:0] q;
    q = 32'h00000000;
    if (fs != '0)
      q = {1'b0, mv, 15'h0000} / {16'h0000, fs};
    if (fs == '0 || q > 32'(dao_pkg::AMP_SAT))
      to_code = dao_pkg::AMP_SAT;
    else
      to_code = q[dao_pkg::AMP_W-1:0];
  endfunction : to_code

  function automatic logic [dao_pkg::AMP_W-1:0] rel_gain(
    input logic [dao_pkg::AMP_W-1:0] base,
    input logic [7:0]                db);
    logic [31:0] p;
    logic [7:0]  oct;
    p   = 32'(base) * 32'(dao_pkg::db_frac(db % dao_pkg::DB_STEP));
    oct = db / dao_pkg::DB_STEP;
    p   = p >> dao_pkg::AMP_FRAC;
    rel_gain = (oct > 8'h10) ? '0 : 16'(p >> oct);
  endfunction : rel_gain

  // (RULE15) analog reference conversion
  assign ref_code = ctrl[dao_pkg::CTRL_REFAN] ? to_code(rel_ref, vpfs)
                                              : rel_ref;

  assign res_eff = (res < dao_pkg::RES_MIN) ? dao_pkg::RES_MIN :
                   (res > dao_pkg::RES_MAX) ? dao_pkg::RES_MAX : res;
  // (RULE9) LSB weight set by resolution
  assign shift = 5'(dao_pkg::SAMPLE_W) - res_eff;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      out_active <= 2'b00;
    else
      out_active <= {2{out_on}} & ctrl[dao_pkg::CTRL_EN +: 2];
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      out_valid <= 1'b0;
    else
      out_valid <= sample_tick;
  end

  assign out_data.ch_a = out_s[0];
  assign out_data.ch_b = out_s[1];

  // ---------------- per-channel datapath ----------------
  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    localparam logic [31:0] SEED = (g == 0) ? dao_pkg::SEED_A
                                            : dao_pkg::SEED_B;
    localparam logic [4:0]  RSH  = 5'(dao_pkg::RAND_W);

    logic [31:0]                        lfsr;
    logic signed [dao_pkg::DITH_W-1:0]  u1;
    logic signed [dao_pkg::DITH_W-1:0]  u2;
    logic signed [dao_pkg::DITH_W-1:0]  tri_now;
    logic signed [dao_pkg::DITH_W-1:0]  tri_prev;
    logic signed [dao_pkg::DITH_W-1:0]  dith;
    logic signed [40:0]                 prod;
    logic signed [26:0]                 acc;
    logic signed [dao_pkg::SAMPLE_W-1:0] sat;
    logic [dao_pkg::SAMPLE_W-1:0]       mask;

    // (RULE16) one step per sample
    always_ff @(posedge mclk or posedge reset)
    begin
      if (reset)
        lfsr <= SEED;
      else if (sample_tick)
        lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end

    always_ff @(posedge mclk or posedge reset)
    begin
      if (reset)
        tri_prev <= '0;
      else if (sample_tick)
        tri_prev <= tri_now;
    end

    // (RULE14) decibels on reference; (RULE4) own amplitude
    always_ff @(posedge mclk or posedge reset)
    begin
      if (reset)
        amp_eff[g] <= '0;
      else
        case (unit)
          dao_pkg::DAO_UNIT_ANALOG: amp_eff[g] <= to_code(amp_sel[g], vpfs);
          dao_pkg::DAO_UNIT_REL:
            amp_eff[g] <= rel_gain(ref_code, amp_sel[g][7:0]);
          default:                  amp_eff[g] <= amp_sel[g];
        endcase
    end

    always_comb
    begin
      u1 = DITH_EXT(lfsr[17:0]) >>> (RSH - shift);
      u2 = DITH_EXT({lfsr[31:18], lfsr[3:0]}) >>> (RSH - shift);
      // (RULE10) two half-LSB terms sum to one LSB
      tri_now = u1 + u2;
      dith = '0;
      case (dith_type)
        dao_pkg::DAO_DITH_TRI:    dith = tri_now;
        // (RULE11) half-LSB uniform
        dao_pkg::DAO_DITH_RECT:   dith = u1;
        // (RULE12) first difference halved, gain one at Nyquist
        dao_pkg::DAO_DITH_SHAPED: dith = (tri_now - tri_prev) >>> 1;
        // (RULE13) no dither
        default:                  dith = '0;
      endcase
      // below one LSB of shift the dither would exceed the word
      if (shift == 5'h00)
        dith = '0;
    end

    function automatic logic signed [dao_pkg::DITH_W-1:0] DITH_EXT(
      input logic [dao_pkg::RAND_W-1:0] r);
      DITH_EXT = dao_pkg::DITH_W'($signed(r));
    endfunction : DITH_EXT

    always_comb
    begin
      // (RULE7) amplitude code scales to peak
      prod = in_s[g] * $signed({1'b0, amp_eff[g]});
      acc  = 27'(prod >>> dao_pkg::AMP_FRAC);
      // (RULE2) negate; (RULE3) same sign path for both
      if (ctrl[dao_pkg::CTRL_INV + g])
        acc = -acc;
      // (RULE8) dither joins ahead of the quantizer
      acc = acc + 27'(dith);
      if (acc[26:23] == 4'h0 || acc[26:23] == 4'hF)
        sat = acc[23:0];
      else
        sat = acc[26] ? dao_pkg::SMP_MIN : dao_pkg::SMP_MAX;
      mask = ~((24'h000001 << shift) - 24'h000001);
    end

    // (RULE1) gate by channel select and master state
    always_ff @(posedge mclk or posedge reset)
    begin
      if (reset)
        out_s[g] <= '0;
      else if (sample_tick)
        out_s[g] <= (out_on && ctrl[dao_pkg::CTRL_EN + g])
                    ? (sat & mask) : '0;
    end
  end
endmodule : dao_output_stage

// file: include/dao_pkg.sv
// shared constants, types and tables of the audio output stage
// assumes APB with 32-bit data and one sample pair per sample tick
package dao_pkg;

  localparam int SAMPLE_W = 24;
  localparam int AMP_W    = 16;
  localparam int RAND_W   = 18;
  localparam int DITH_W   = 20;
  localparam int ADDR_W   = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TOGGLE  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_AMP_A   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_AMP_B   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_REL_REF = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_VPFS    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_RES     = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h1C;

  // control and status field positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_INV   = 2;
  localparam int CTRL_TRACK = 4;
  localparam int CTRL_DITH  = 5;
  localparam int CTRL_UNIT  = 7;
  localparam int CTRL_REFAN = 9;
  localparam int CTRL_W     = 10;
  localparam int STAT_ON    = 0;
  localparam int STAT_UNDER = 1;
  localparam int STAT_LVL   = 4;

  // reset values and resolution limits
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h003;
  localparam logic [AMP_W-1:0]  AMP_RST  = 16'h0000;
  localparam logic [AMP_W-1:0]  REF_RST  = 16'h8000;
  localparam logic [AMP_W-1:0]  VPFS_RST = 16'h03E8;
  localparam logic [4:0]        RES_RST  = 5'h10;
  localparam logic [4:0]        RES_MIN  = 5'h08;
  localparam logic [4:0]        RES_MAX  = 5'h18;

  localparam logic [AMP_W-1:0]    AMP_SAT  = 16'hFFFF;
  localparam logic [7:0]          DB_STEP  = 8'h06;
  localparam logic [4:0]          AMP_FRAC = 5'h0F;
  localparam logic [SAMPLE_W-1:0] SMP_MAX  = 24'h7FFFFF;
  localparam logic [SAMPLE_W-1:0] SMP_MIN  = 24'h800000;
  localparam logic [31:0]         SEED_A   = 32'h1D872B41;
  localparam logic [31:0]         SEED_B   = 32'h6A09E667;

  typedef enum logic [1:0]
  {
    DAO_DITH_NONE   = 2'h0,
    DAO_DITH_TRI    = 2'h1,
    DAO_DITH_RECT   = 2'h2,
    DAO_DITH_SHAPED = 2'h3
  } dao_dither_e;

  typedef enum logic [1:0]
  {
    DAO_UNIT_CODE   = 2'h0,
    DAO_UNIT_ANALOG = 2'h1,
    DAO_UNIT_REL    = 2'h2
  } dao_unit_e;

  typedef struct packed
  {
    logic signed [SAMPLE_W-1:0] ch_b;
    logic signed [SAMPLE_W-1:0] ch_a;
  } dao_pair_s;

  // Q15 gain of 0..5 dB attenuation; each further 6 dB halves
  function automatic logic [AMP_W-1:0] db_frac(input logic [7:0] idx);
    case (idx)
      8'h00:   db_frac = 16'h8000;
      8'h01:   db_frac = 16'h7215;
      8'h02:   db_frac = 16'h65AD;
      8'h03:   db_frac = 16'h5A9E;
      8'h04:   db_frac = 16'h50C3;
      default: db_frac = 16'h47FB;
    endcase
  endfunction : db_frac

endpackage : dao_pkg

// file: testbench/dao_far_end.sv
// far end model: the receiver that asks for one sample per tick
// assumes the bench calls ticks; gap sets a prompt or slow rate
module dao_far_end (
  input wire logic mclk,
  output logic     sample_tick
);
  timeunit 1ns;
  timeprecision 100ps;

  initial sample_tick = 1'b0;

  // ticks always one cycle apart at least, as the stage needs
  task automatic ticks(input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      sample_tick <= 1'b1;
      @(posedge mclk);
      sample_tick <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask : ticks
endmodule : dao_far_end

// file: testbench/dao_output_stage_sva.sv
// port checker of the audio output stage
// assumes one clock mclk and reset held high at start
module dao_output_stage_sva (
  input wire logic               mclk,
  input wire logic               reset,
  input wire logic [7:0]         paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               src_valid,
  input wire logic               src_ready,
  input wire dao_pkg::dao_pair_s src_data,
  input wire logic               sample_tick,
  input wire logic               out_valid,
  input wire dao_pkg::dao_pair_s out_data,
  input wire logic [1:0]         out_active
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_off_zero_a: assert property (
    out_valid && !out_active[0] && $stable(out_active) |->
      out_data.ch_a == 24'h0) else $error("channel a driven while idle");
  a_off_zero_b: assert property (
    out_valid && !out_active[1] && $stable(out_active) |->
      out_data.ch_b == 24'h0) else $error("channel b driven while idle");
  a_toggle_off: assert property (
    psel && penable && pwrite && paddr == dao_pkg::ADDR_TOGGLE &&
      pwdata[0] && out_active == 2'h3 |-> ##2 out_active == 2'h0)
    else $error("toggle did not turn output off");
  a_tick_answer: assert property (
    sample_tick |=> out_valid) else $error("no sample after tick");
  a_valid_cause: assert property (
    out_valid |-> $past(sample_tick)) else $error("sample without tick");
  a_out_holds: assert property (
    !out_valid |-> $stable(out_data)) else $error("output moved idle");
  a_zero_wait: assert property (
    pready == (psel && penable)) else $error("pready not in access");
  a_unmapped_err: assert property (
    psel && !penable && paddr > 8'h1C |=> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  a_read_stands: assert property (
    !(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
  a_full_holds: assert property (
    src_valid && !src_ready && !sample_tick |=> !src_ready)
    else $error("full fifo accepted without pop");

  c_sample: cover property (sample_tick ##1 out_valid);
  c_full: cover property (src_valid && !src_ready);
  c_error: cover property (psel && penable && pslverr);
endmodule : dao_output_stage_sva

bind dao_output_stage dao_output_stage_sva chk (.mclk, .reset, .paddr,
  .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .src_valid, .src_ready, .src_data, .sample_tick, .out_valid, .out_data,
  .out_active);

// file: testbench/test_dao_output_stage.sv
// self-checking bench of the audio output stage
// assumes dao_far_end supplies sample ticks on request
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %0h seen %0h", nm, e, g); \
end end
module test_dao_output_stage;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic signed [23:0] lo [2];
    logic signed [23:0] hi [2];
    logic [23:0]        lowm;
    logic               dith;
  } dao_note_s;
  localparam logic [31:0] RV [8] = '{32'h3, 32'h0, 32'h0, 32'h0,
    32'h8000, 32'h3E8, 32'h10, 32'h0};
  logic               mclk, reset, psel, penable, pwrite, src_valid;
  logic               pready, pslverr, src_ready, sample_tick, out_valid;
  logic               m_on, ev;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rdv;
  logic [1:0]         out_active;
  logic [9:0]         m_ctrl;
  logic [15:0]        g_a, g_b;
  logic [4:0]         m_res;
  logic signed [23:0] got [2];
  dao_pkg::dao_pair_s src_data, out_data;
  dao_note_s          notes[$];
  dao_note_s          nt;
  int                 err_count, check_count, diffs;

  dao_output_stage dut (.mclk, .reset, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .src_valid, .src_ready, .src_data,
    .sample_tick, .out_valid, .out_data, .out_active);
  dao_far_end far (.mclk, .sample_tick);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic stuck(input string what);
    err_count++;
    $display("unexpected %s never came", what);
    test_done();
  endtask : stuck

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) stuck("pready");
    rdv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic push(input logic signed [23:0] a,
                      input logic signed [23:0] b);
    int n;
    @(posedge mclk);
    src_valid <= 1'b1;
    src_data <= {b, a};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (src_ready !== 1'b1 && n < 20);
    if (n >= 20) stuck("src_ready");
    src_valid <= 1'b0;
  endtask : push

  // expected pair from the bench's own copy of the settings
  function automatic dao_note_s mk(input logic signed [23:0] a,
                                   input logic signed [23:0] b);
    dao_note_s          n;
    logic signed [47:0] v;
    logic signed [23:0] d;
    n.lowm = (24'h1 << (5'd24 - m_res)) - 24'h1;
    n.dith = m_ctrl[6:5] != 2'h0 && m_res != 5'h18;
    for (int c = 0; c < 2; c++)
    begin
      v = (c ? b : a) * $signed({1'b0, (c && !m_ctrl[4]) ? g_b : g_a});
      v = v >>> 15;
      if (m_ctrl[2 + c]) v = -v;
      v = (m_on && m_ctrl[c]) ? v & ~{24'h0, n.lowm} : 48'sh0;
      d = (m_on && m_ctrl[c] && n.dith) ? 24'(n.lowm + 24'h1) : 24'sh0;
      n.lo[c] = v[23:0] - d;
      n.hi[c] = (m_ctrl[6:5] == 2'h2) ? v[23:0] : v[23:0] + d;
    end
    return n;
  endfunction : mk

  function automatic logic signed [23:0] inr(input logic signed [23:0] g,
    input logic signed [23:0] lo, input logic signed [23:0] hi);
    return (g >= lo && g <= hi) ? lo : g;
  endfunction : inr

  task automatic drain();
    int n;
    n = 0;
    while (notes.size() != 0 && n < 200)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) stuck("out_valid");
  endtask : drain

  task automatic fill();
    logic signed [23:0] a;
    for (int i = 0; i < 4; i++)
    begin
      a = 24'($urandom_range(16383) << 8) - 24'h200000;
      notes.push_back(mk(a, a + 24'h000200));
      push(a, a + 24'h000200);
    end
  endtask : fill

  task automatic run(input int gap);
    fill();
    far.ticks(4, gap);
    drain();
  endtask : run

  task automatic cfg(input logic [9:0] c);
    m_ctrl = c;
    apb(1'b1, dao_pkg::ADDR_CTRL, {22'h0, c});
    repeat (3) @(posedge mclk);
  endtask : cfg

  task automatic amps(input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] ga, input logic [15:0] gb);
    apb(1'b1, dao_pkg::ADDR_AMP_A, {16'h0, a});
    apb(1'b1, dao_pkg::ADDR_AMP_B, {16'h0, b});
    g_a = ga;
    g_b = gb;
  endtask : amps

  always @(posedge mclk)
    if (out_valid === 1'b1)
    begin
      if (notes.size() == 0)
        `CHK("spare out_valid", 1'b0, out_valid)
      else
      begin
        nt = notes.pop_front();
        got[0] = out_data.ch_a;
        got[1] = out_data.ch_b;
        for (int c = 0; c < 2; c++)
        begin
          `CHK("channel", nt.lo[c], inr(got[c], nt.lo[c], nt.hi[c]))
          `CHK("low bits", 24'h0, got[c] & nt.lowm)
        end
        if (nt.dith && got[0] - nt.lo[0] != got[1] - nt.lo[1])
          diffs++;
      end
    end

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_valid = 1'b0;
    src_data = '0;
    m_on = 1'b0;
    m_ctrl = 10'h003;
    m_res = 5'h10;
    void'($urandom(32'hA0D740B5));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset value", RV[i], rdv)
      `CHK("mapped pslverr", 1'b0, ev)
    end
    apb(1'b1, 8'h20, 32'hFFFF);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("pslverr", 1'b1, ev)
    `CHK("unmapped", 32'h0, rdv)
    amps(16'h8000, 16'h8000, 16'h8000, 16'h8000);
    run(0);
    apb(1'b1, dao_pkg::ADDR_TOGGLE, 32'h1);
    m_on = 1'b1;
    apb(1'b0, dao_pkg::ADDR_TOGGLE, 32'h0);
    `CHK("on", 1'b1, rdv[0])
    apb(1'b1, dao_pkg::ADDR_RES, 32'h18);
    m_res = 5'h18;
    for (int i = 0; i < 4; i++)
    begin
      // each invert pattern at peak code, then each channel enable pattern at a slower tick
      cfg({6'h0, 2'(i), 2'h3});
      run(0);
      cfg({8'h0, 2'(i)});
      `CHK("out_active", 2'(i), out_active)
      run(1);
    end
    // own gains, then channel a gain on both
    cfg(10'h003);
    amps(16'h4000, 16'h8000, 16'h4000, 16'h8000);
    run(2);
    cfg(10'h013);
    amps(16'h4000, 16'h1000, 16'h4000, 16'h1000);
    run(0);
    // millivolts against volts per full scale of 1000
    cfg(10'h083);
    amps(16'd500, 16'd250, 16'h4000, 16'h2000);
    run(0);
    // decibels below code and millivolt reference
    cfg(10'h103);
    amps(16'd6, 16'd12, 16'h4000, 16'h2000);
    run(0);
    apb(1'b1, dao_pkg::ADDR_REL_REF, 32'd500);
    cfg(10'h303);
    amps(16'd6, 16'd0, 16'h2000, 16'h4000);
    run(0);
    amps(16'h8000, 16'h8000, 16'h8000, 16'h8000);
    for (int r = 0; r < 2; r++)
      for (int d = 0; d < 4; d++)
      begin
        m_res = r ? 5'h14 : 5'h10;
        apb(1'b1, dao_pkg::ADDR_RES, {27'h0, m_res});
        cfg({3'h0, 2'(d), 5'h03});
        repeat (4) run(0);
      end
    `CHK("dither spread", 1'b1, diffs > 0)
    cfg(10'h003);
    apb(1'b1, dao_pkg::ADDR_TOGGLE, 32'h1);
    m_on = 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("out_active off", 2'h0, out_active)
    run(0);
    apb(1'b1, dao_pkg::ADDR_TOGGLE, 32'h1);
    m_on = 1'b1;
    // fifo refusal, slow drain and underrun
    fill();
    // let the last push release valid before raising it again
    @(posedge mclk);
    src_valid <= 1'b1;
    repeat (2) @(posedge mclk);
    src_valid <= 1'b0;
    `CHK("src_ready full", 1'b0, src_ready)
    apb(1'b0, dao_pkg::ADDR_STATUS, 32'h0);
    `CHK("level", 3'h4, rdv[6:4])
    far.ticks(4, 5);
    drain();
    notes.push_back(mk(24'sh0, 24'sh0));
    far.ticks(1, 0);
    drain();
    apb(1'b0, dao_pkg::ADDR_STATUS, 32'h0);
    `CHK("underrun", 1'b1, rdv[1])
    apb(1'b1, dao_pkg::ADDR_STATUS, 32'h2);
    apb(1'b0, dao_pkg::ADDR_STATUS, 32'h0);
    `CHK("underrun clear", 1'b0, rdv[1])
    test_done();
  end
endmodule : test_dao_output_stage
